// ===== hdl/lpm_ctrl.sv
// Low-power mode controller with AHB-Lite register slave
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module lpm_ctrl #(
  parameter int unsigned WU_F0 = lpm_pkg::WU_F0_CYC,
  parameter int unsigned WU_F1 = lpm_pkg::WU_F1_CYC,
  parameter int unsigned WU_F2 = lpm_pkg::WU_F2_CYC,
  parameter int unsigned WU_F3 = lpm_pkg::WU_F3_CYC,
  parameter int unsigned WU_S0 = lpm_pkg::WU_S0_CYC,
  parameter int unsigned WU_S1 = lpm_pkg::WU_S1_CYC,
  parameter int unsigned WU_S2 = lpm_pkg::WU_S2_CYC,
  parameter int unsigned WU_S3 = lpm_pkg::WU_S3_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wake_n,
  input wire logic tick_src,
  input wire logic wdt_irq,
  input wire logic [lpm_pkg::IRQ_N-1:0] irq_pending,
  output lpm_pkg::lpm_ctrl_t ctrl
);
  lpm_pkg::lpm_state_t state_reg, state_next;
  lpm_pkg::lpm_run_t run_reg;
  lpm_pkg::lpm_ctrl_t ctrl_reg, ctrl_next;
  localparam int WCW_L = lpm_pkg::WCW;
  logic [WCW_L-1:0] cnt_reg, cnt_next;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic go_reg;
  logic slow_reg;
  logic sense_reg;
  logic sense_eff_reg;
  logic [1:0] wu_reg;
  logic dual_reg;
  logic cpu_req_reg;
  logic tick_req_reg;
  logic gie_reg;
  logic tie_reg;
  logic tte_reg;
  logic [lpm_pkg::IRQ_N-1:0] src_en_reg;
  logic wake_d_reg;
  logic tick_d_reg;
  logic hf_reg;
  logic lf_reg;
  logic wake_rise;
  logic tick_fall;
  logic halt_wake;
  logic cpu_wake;
  logic wr_c1;
  logic wr_c2;
  logic wr_ic;
  logic addr_ok;
  logic cpu_enter;
  logic tick_enter;
  logic wdt_cancel;

  function automatic logic [lpm_pkg::WCW-1:0] warm_cycles(
    input logic [1:0] sel,
    input logic slow
  );
    int unsigned v;
    case ({slow, sel})
      3'h0: v = WU_F0;
      3'h1: v = WU_F1;
      3'h2: v = WU_F2;
      3'h3: v = WU_F3;
      3'h4: v = WU_S0;
      3'h5: v = WU_S1;
      3'h6: v = WU_S2;
      default: v = WU_S3;
    endcase
    return lpm_pkg::WCW'(v - 1);
  endfunction

  function automatic lpm_pkg::lpm_run_t run_of(
    input logic dual,
    input logic slow
  );
    if (!dual) begin
      return lpm_pkg::FAST_RUN_SINGLE;
    end else if (slow) begin
      return lpm_pkg::SLOW_RUN;
    end else begin
      return lpm_pkg::FAST_RUN_DUAL;
    end
  endfunction

  assign addr_ok = hsel && hready && htrans[1];
  assign wr_c1 = wr_pend_reg && addr_reg == lpm_pkg::ADDR_CTRL1;
  assign wr_c2 = wr_pend_reg && addr_reg == lpm_pkg::ADDR_CTRL2;
  assign wr_ic = wr_pend_reg && addr_reg == lpm_pkg::ADDR_IRQCFG;
  assign wake_rise = wake_n && !wake_d_reg;
  assign tick_fall = !tick_src && tick_d_reg;
  assign cpu_wake = |(irq_pending & src_en_reg);
  assign halt_wake = sense_eff_reg ? wake_n : wake_rise;
  assign wdt_cancel = state_reg == lpm_pkg::LPM_RUN && wdt_irq &&
    (cpu_req_reg || tick_req_reg);
  assign cpu_enter = state_reg == lpm_pkg::LPM_RUN && cpu_req_reg && !wdt_irq;
  assign tick_enter = state_reg == lpm_pkg::LPM_RUN && tick_req_reg &&
    !wdt_irq;

  // Bus slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_ok && hwrite;
      addr_reg <= haddr[7:0];
      hrdata <= 32'h00000000;
      if (addr_ok && !hwrite && haddr[31:8] == 24'h000000) begin
        if (haddr[7:0] == lpm_pkg::ADDR_CTRL1) begin
          hrdata[lpm_pkg::C1_SLOW] <= slow_reg;
          hrdata[lpm_pkg::C1_SENSE] <= sense_reg;
          hrdata[lpm_pkg::C1_WU +: 2] <= wu_reg;
          hrdata[lpm_pkg::C1_DUAL] <= dual_reg;
        end else if (haddr[7:0] == lpm_pkg::ADDR_CTRL2) begin
          hrdata[lpm_pkg::C2_CPU] <= cpu_req_reg;
          hrdata[lpm_pkg::C2_TICK] <= tick_req_reg;
        end else if (haddr[7:0] == lpm_pkg::ADDR_IRQCFG) begin
          hrdata[lpm_pkg::IC_GIE] <= gie_reg;
          hrdata[lpm_pkg::IC_TIE] <= tie_reg;
          hrdata[lpm_pkg::IC_TTE] <= tte_reg;
          hrdata[lpm_pkg::IC_SRC +: lpm_pkg::IRQ_N] <= src_en_reg;
        end else if (haddr[7:0] == lpm_pkg::ADDR_STATUS) begin
          hrdata[2:0] <= state_reg;
          hrdata[5:4] <= run_reg;
          hrdata[8] <= sense_eff_reg;
          hrdata[9] <= wake_n;
          hrdata[10] <= hf_reg;
          hrdata[11] <= lf_reg;
        end
      end
    end
  end

  // Mode control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_reg <= 1'b0;
      sense_reg <= 1'b0;
      wu_reg <= lpm_pkg::WU_RESET;
      dual_reg <= 1'b0;
      gie_reg <= 1'b0;
      tie_reg <= 1'b0;
      tte_reg <= 1'b0;
      src_en_reg <= '0;
    end else begin
      if (wr_c1) begin
        slow_reg <= hwdata[lpm_pkg::C1_SLOW];
        sense_reg <= hwdata[lpm_pkg::C1_SENSE];
        wu_reg <= hwdata[lpm_pkg::C1_WU +: 2];
        dual_reg <= hwdata[lpm_pkg::C1_DUAL];
      end
      if (wr_ic) begin
        gie_reg <= hwdata[lpm_pkg::IC_GIE];
        tie_reg <= hwdata[lpm_pkg::IC_TIE];
        tte_reg <= hwdata[lpm_pkg::IC_TTE];
        src_en_reg <= hwdata[lpm_pkg::IC_SRC +: lpm_pkg::IRQ_N];
      end
    end
  end

  // Halt command, taken once in run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_reg <= 1'b0;
    end else if (wr_c1 && hwdata[lpm_pkg::C1_GO]) begin
      go_reg <= 1'b1;
    end else if (state_reg == lpm_pkg::LPM_RUN) begin
      go_reg <= 1'b0;
    end
  end

  // Doze requests, a write wins over the hardware clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_req_reg <= 1'b0;
      tick_req_reg <= 1'b0;
    end else begin
      if (wr_c2) begin
        cpu_req_reg <= hwdata[lpm_pkg::C2_CPU];
      end else if ((state_reg == lpm_pkg::LPM_CDOZE && cpu_wake) ||
                   wdt_cancel) begin
        cpu_req_reg <= 1'b0;
      end
      if (wr_c2) begin
        tick_req_reg <= hwdata[lpm_pkg::C2_TICK];
      end else if ((state_reg == lpm_pkg::LPM_TDOZE && tick_fall) ||
                   wdt_cancel) begin
        tick_req_reg <= 1'b0;
      end
    end
  end

  // Pin history and effective release sense
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Idle pin level, no false rise after reset
      wake_d_reg <= 1'b1;
      tick_d_reg <= 1'b0;
      sense_eff_reg <= 1'b0;
    end else begin
      wake_d_reg <= wake_n;
      tick_d_reg <= tick_src;
      if (!sense_reg) begin
        sense_eff_reg <= 1'b0;
      end else if (wake_rise) begin
        sense_eff_reg <= 1'b1;
      end
    end
  end

  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      lpm_pkg::LPM_RUN: begin
        if (go_reg) begin
          if (sense_eff_reg && wake_n) begin
            state_next = lpm_pkg::LPM_WARM;
            cnt_next = warm_cycles(wu_reg, dual_reg && slow_reg);
          end else begin
            state_next = lpm_pkg::LPM_HALT;
          end
        end else if (cpu_enter) begin
          state_next = lpm_pkg::LPM_CDOZE;
        end else if (tick_enter) begin
          state_next = lpm_pkg::LPM_TDOZE;
        end
      end
      lpm_pkg::LPM_HALT: begin
        if (halt_wake) begin
          state_next = lpm_pkg::LPM_WARM;
          cnt_next = warm_cycles(wu_reg, dual_reg && slow_reg);
        end
      end
      lpm_pkg::LPM_WARM: begin
        if (cnt_reg == '0) begin
          state_next = lpm_pkg::LPM_RUN;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      lpm_pkg::LPM_CDOZE: begin
        if (cpu_wake) begin
          state_next = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_TDOZE: begin
        if (tick_fall) begin
          state_next = lpm_pkg::LPM_RUN;
        end
      end
      default: state_next = lpm_pkg::LPM_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= lpm_pkg::LPM_RUN;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= lpm_pkg::FAST_RUN_SINGLE;
    end else if (state_reg == lpm_pkg::LPM_RUN &&
                 state_next == lpm_pkg::LPM_RUN) begin
      run_reg <= run_of(dual_reg, slow_reg);
    end
  end

  // Oscillator enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_reg <= 1'b1;
      lf_reg <= 1'b0;
    end else if (state_next == lpm_pkg::LPM_HALT) begin
      hf_reg <= 1'b0;
      lf_reg <= 1'b0;
    end else if (state_next == lpm_pkg::LPM_WARM &&
                 state_reg != lpm_pkg::LPM_WARM) begin
      hf_reg <= !(dual_reg && slow_reg);
      lf_reg <= dual_reg;
    end
  end

  // Control outputs
  always_comb begin
    ctrl_next = '0;
    ctrl_next.hf_osc_en = hf_reg;
    ctrl_next.lf_osc_en = lf_reg;
    ctrl_next.periph_clk_en = 1'b1;
    if (state_next == lpm_pkg::LPM_HALT && state_reg == lpm_pkg::LPM_RUN) begin
      ctrl_next.hf_osc_en = 1'b0;
      ctrl_next.lf_osc_en = 1'b0;
    end else if (state_next == lpm_pkg::LPM_WARM &&
                 state_reg != lpm_pkg::LPM_WARM) begin
      ctrl_next.hf_osc_en = !(dual_reg && slow_reg);
      ctrl_next.lf_osc_en = dual_reg;
      ctrl_next.prescaler_clr = 1'b1;
    end else if (state_next == lpm_pkg::LPM_HALT) begin
      ctrl_next.hf_osc_en = 1'b0;
      ctrl_next.lf_osc_en = 1'b0;
    end
    ctrl_next.pc_hold = state_next != lpm_pkg::LPM_RUN;
    if (state_next == lpm_pkg::LPM_HALT || state_next == lpm_pkg::LPM_WARM) begin
      ctrl_next.core_halt = 1'b1;
      ctrl_next.cpu_halt = 1'b1;
      ctrl_next.wdt_halt = 1'b1;
      ctrl_next.periph_clk_en = 1'b0;
    end
    if (state_next == lpm_pkg::LPM_CDOZE) begin
      ctrl_next.cpu_halt = 1'b1;
      ctrl_next.wdt_halt = 1'b1;
    end
    if (state_next == lpm_pkg::LPM_TDOZE) begin
      ctrl_next.cpu_halt = 1'b1;
      ctrl_next.wdt_halt = 1'b1;
      ctrl_next.periph_clk_en = 1'b0;
    end
    ctrl_next.tick_latch_set = tick_enter && !go_reg && !cpu_req_reg && tte_reg;
    ctrl_next.resume = state_reg != lpm_pkg::LPM_RUN &&
      state_next == lpm_pkg::LPM_RUN;
    ctrl_next.vector_req = (state_reg == lpm_pkg::LPM_CDOZE && cpu_wake &&
      gie_reg) || (wdt_cancel && !go_reg);
    ctrl_next.vector_tick = state_reg == lpm_pkg::LPM_TDOZE && tick_fall &&
      gie_reg && tie_reg && tte_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= '{hf_osc_en: 1'b1, periph_clk_en: 1'b1, default: 1'b0};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  assign ctrl = ctrl_reg;

  halt_osc_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_HALT |-> !ctrl.hf_osc_en && !ctrl.lf_osc_en
  ) else $error("oscillator running in halt");
  edge_wake_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_HALT && !sense_eff_reg && !wake_rise
    |=> state_reg == lpm_pkg::LPM_HALT
  ) else $error("edge mode left halt without rising edge");
  edge_enter_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_RUN && go_reg && !sense_eff_reg
    |=> state_reg == lpm_pkg::LPM_HALT
  ) else $error("edge mode did not enter halt");
  warm_no_halt_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_WARM |=> state_reg != lpm_pkg::LPM_HALT
  ) else $error("halt re-entered during warm-up");
  sense_defer_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(sense_eff_reg) |-> $past(wake_rise)
  ) else $error("level sense taken without rising edge");
  warm_osc_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_HALT && halt_wake && dual_reg && !slow_reg
    |=> ctrl.hf_osc_en && ctrl.lf_osc_en && ctrl.prescaler_clr
  ) else $error("dual fast release oscillators wrong");
  warm_resume_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_WARM && cnt_reg == '0
    |=> ctrl.resume && !ctrl.pc_hold ##1 !ctrl.resume
  ) else $error("resume pulse after warm-up wrong");
  cdoze_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_CDOZE
    |-> ctrl.cpu_halt && ctrl.wdt_halt && ctrl.periph_clk_en && ctrl.pc_hold
  ) else $error("CPU doze outputs wrong");
  wdt_cancel_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wdt_cancel && !go_reg |=> state_reg == lpm_pkg::LPM_RUN && ctrl.vector_req
  ) else $error("doze entered despite watchdog irq");
  tick_vec_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_reg == lpm_pkg::LPM_TDOZE && tick_fall
    |=> state_reg == lpm_pkg::LPM_RUN && !tick_req_reg &&
        ctrl.vector_tick == $past(gie_reg && tie_reg && tte_reg)
  ) else $error("tick doze release wrong");
endmodule

// ===== hdl/lpm_pkg.sv
// Constants and types of the low-power mode controller
package lpm_pkg;
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_IRQCFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int C1_GO = 7;
  localparam int C1_SLOW = 6;
  localparam int C1_SENSE = 5;
  localparam int C1_WU = 3;
  localparam int C1_DUAL = 0;
  localparam int C2_CPU = 4;
  localparam int C2_TICK = 2;
  localparam int IC_GIE = 0;
  localparam int IC_TIE = 1;
  localparam int IC_TTE = 2;
  localparam int IC_SRC = 8;
  localparam int IRQ_N = 8;
  localparam logic [1:0] WU_RESET = 2'h0;
  localparam int WCW = 27;
  localparam real CLK_NS = 8.0;
  localparam real WU_F0_MS = 12.288;
  localparam real WU_F1_MS = 4.096;
  localparam real WU_F2_MS = 3.072;
  localparam real WU_F3_MS = 1.024;
  localparam real WU_S0_MS = 750.0;
  localparam real WU_S1_MS = 250.0;
  localparam real WU_S2_MS = 5.85;
  localparam real WU_S3_MS = 1.95;
  localparam int unsigned WU_F0_CYC = int'($ceil(WU_F0_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_F1_CYC = int'($ceil(WU_F1_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_F2_CYC = int'($ceil(WU_F2_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_F3_CYC = int'($ceil(WU_F3_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_S0_CYC = int'($ceil(WU_S0_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_S1_CYC = int'($ceil(WU_S1_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_S2_CYC = int'($ceil(WU_S2_MS * 1.0e6 / CLK_NS));
  localparam int unsigned WU_S3_CYC = int'($ceil(WU_S3_MS * 1.0e6 / CLK_NS));
  typedef enum logic [2:0] {
    LPM_RUN, LPM_HALT, LPM_WARM, LPM_CDOZE, LPM_TDOZE
  } lpm_state_t;
  typedef enum logic [1:0] {
    FAST_RUN_SINGLE, FAST_RUN_DUAL, SLOW_RUN
  } lpm_run_t;
  typedef struct packed {
    logic hf_osc_en;
    logic lf_osc_en;
    logic core_halt;
    logic cpu_halt;
    logic wdt_halt;
    logic periph_clk_en;
    logic pc_hold;
    logic prescaler_clr;
    logic tick_latch_set;
    logic resume;
    logic vector_req;
    logic vector_tick;
  } lpm_ctrl_t;
endpackage

// ===== bench/lpm_far_side.sv
// Far-side model: wake pin and tick source
`timescale 1ns/1ns
module lpm_far_side (
  input wire logic hclk,
  output logic wake_n,
  output logic tick_src
);
  initial begin
    wake_n = 1'b1;
    tick_src = 1'b1;
  end
  task automatic set_wake(input logic lvl);
    @(posedge hclk);
    wake_n <= lvl;
    repeat (4) @(posedge hclk);
  endtask
  task automatic tick_fall();
    @(posedge hclk);
    tick_src <= 1'b0;
    repeat (4) @(posedge hclk);
    tick_src <= 1'b1;
  endtask
endmodule

// ===== bench/tb_lpm_ctrl.sv
// Self-checking bench of the low-power mode controller
`timescale 1ns/1ns
module tb_lpm_ctrl;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic wake_n;
  logic tick_src;
  logic wdt_irq = 1'b0;
  logic [lpm_pkg::IRQ_N-1:0] irq_pending = 8'h0;
  lpm_pkg::lpm_ctrl_t ctrl;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_res = 0;
  int n_vreq = 0;
  int n_vtick = 0;
  int n_clr = 0;
  int n_lat = 0;
  int warm_cyc = 0;
  logic [1:0] warm_osc = 2'h0;
  logic [31:0] rdata;

  always #4 hclk = ~hclk;

  lpm_ctrl #(.WU_F0(20), .WU_F1(10), .WU_F3(4), .WU_S2(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wake_n(wake_n), .tick_src(tick_src),
    .wdt_irq(wdt_irq), .irq_pending(irq_pending), .ctrl(ctrl)
  );

  lpm_far_side far (.hclk(hclk), .wake_n(wake_n), .tick_src(tick_src));

  // Pulse counters and warm-up length
  always @(posedge hclk) begin
    if (ctrl.resume === 1'b1) n_res++;
    if (ctrl.vector_req === 1'b1) n_vreq++;
    if (ctrl.vector_tick === 1'b1) n_vtick++;
    if (ctrl.tick_latch_set === 1'b1) n_lat++;
    if (ctrl.prescaler_clr === 1'b1) begin
      n_clr++;
      warm_cyc = 1;
      warm_osc = {ctrl.hf_osc_en, ctrl.lf_osc_en};
    end else if (ctrl.core_halt === 1'b1 && ctrl.hf_osc_en === 1'b1)
      warm_cyc++;
    else if (ctrl.core_halt === 1'b1 && ctrl.lf_osc_en === 1'b1)
      warm_cyc++;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic wait_res(input int was);
    int k;
    k = 0;
    while (n_res == was && k < 200) begin
      @(posedge hclk);
      k++;
    end
    #1;
    check("resume", 32'h1, 32'(n_res - was));
  endtask

  task automatic t_reset();
    step(1);
    check("reset ctrl", 32'h840, {20'h0, ctrl});
    check("hresp", 32'h0, {31'h0, hresp});
    check("hreadyout", 32'h1, {31'h0, hreadyout});
    rd_reg(lpm_pkg::ADDR_STATUS);
    check("status", 32'h600, {20'h0, rdata[11:0]});
    rd_reg(lpm_pkg::ADDR_CTRL1);
    check("ctrl1", 32'h0, rdata);
    wr_reg(8'h40, 32'hffffffff);
    rd_reg(8'h40);
    check("unmapped", 32'h0, rdata);
    check("fast 00", 32'd1536000, lpm_pkg::WU_F0_CYC);
    check("slow 00", 32'd93750000, lpm_pkg::WU_S0_CYC);
  endtask

  task automatic t_level();
    int r;
    wr_reg(lpm_pkg::ADDR_CTRL1, 32'h20);
    rd_reg(lpm_pkg::ADDR_STATUS);
    check("sense", 32'h0, {31'h0, rdata[8]});
    far.set_wake(1'b0);
    far.set_wake(1'b1);
    rd_reg(lpm_pkg::ADDR_STATUS);
    check("sense", 32'h1, {31'h0, rdata[8]});
    r = n_res;
    wr_reg(lpm_pkg::ADDR_CTRL1, 32'hb8);
    wait_res(r);
    check("warm skip", 32'd4, 32'(warm_cyc));
    far.set_wake(1'b0);
    r = n_res;
    wr_reg(lpm_pkg::ADDR_CTRL1, 32'ha0);
    step(3);
    check("level halt", 32'h3a0, {20'h0, ctrl});
    far.set_wake(1'b1);
    far.set_wake(1'b0);
    wait_res(r);
    check("warm kept", 32'd20, 32'(warm_cyc));
    far.set_wake(1'b1);
    wr_reg(lpm_pkg::ADDR_CTRL1, 32'h0);
  endtask

  task automatic t_edge_halt();
    logic [7:0] cfg [4] = '{8'h00, 8'h09, 8'h18, 8'h51};
    int wu [4] = '{20, 10, 4, 8};
    logic [1:0] osc [4] = '{2'b10, 2'b11, 2'b10, 2'b01};
    int r;
    int c;
    for (int i = 0; i < 4; i++) begin
      r = n_res;
      c = n_clr;
      wr_reg(lpm_pkg::ADDR_CTRL1, {24'h0, cfg[i] | 8'h80});
      step(3);
      check("halt ctrl", 32'h3a0, {20'h0, ctrl});
      far.set_wake(1'b0);
      check("still halted", 32'h3a0, {20'h0, ctrl});
      far.set_wake(1'b1);
      wait_res(r);
      check("warm count", 32'(wu[i]), 32'(warm_cyc));
      check("warm osc", {30'h0, osc[i]}, {30'h0, warm_osc});
      check("prescaler clear", 32'h1, 32'(n_clr - c));
      check("running", 32'h0, {30'h0, ctrl.core_halt, ctrl.pc_hold});
    end
  endtask

  task automatic t_cpu_doze();
    int r;
    int v;
    logic [1:0] m;
    for (int g = 0; g < 2; g++) begin
      rd_reg(lpm_pkg::ADDR_STATUS);
      m = rdata[5:4];
      r = n_res;
      v = n_vreq;
      wr_reg(lpm_pkg::ADDR_IRQCFG, 32'h0);
      wr_reg(lpm_pkg::ADDR_IRQCFG, {16'h0, 8'h01, 7'h0, g[0]});
      wr_reg(lpm_pkg::ADDR_CTRL2, 32'h10);
      step(3);
      check("doze ctrl", 32'h0f, {27'h0, ctrl[9:5]});
      @(posedge hclk);
      irq_pending <= 8'h02;
      step(4);
      check("masked irq", 32'h0f, {27'h0, ctrl[9:5]});
      @(posedge hclk);
      irq_pending <= 8'h03;
      wait_res(r);
      check("vector", 32'(g), 32'(n_vreq - v));
      @(posedge hclk);
      irq_pending <= 8'h00;
      rd_reg(lpm_pkg::ADDR_CTRL2);
      check("doze bit", 32'h0, {31'h0, rdata[4]});
      rd_reg(lpm_pkg::ADDR_STATUS);
      check("run mode", {30'h0, m}, {30'h0, rdata[5:4]});
    end
  endtask

  task automatic t_wdt();
    int v;
    for (int b = 2; b < 5; b += 2) begin
      v = n_vreq;
      @(posedge hclk);
      wdt_irq <= 1'b1;
      wr_reg(lpm_pkg::ADDR_CTRL2, 32'h1 << b);
      step(3);
      check("wdt vector", 32'h1, 32'(n_vreq - v));
      check("no doze", 32'h0, {31'h0, ctrl.pc_hold});
      @(posedge hclk);
      wdt_irq <= 1'b0;
      rd_reg(lpm_pkg::ADDR_CTRL2);
      check("request", 32'h0, rdata & 32'h14);
    end
  endtask

  task automatic t_tick();
    int r;
    int l;
    int vt;
    for (int t = 0; t < 2; t++) begin
      r = n_res;
      l = n_lat;
      vt = n_vtick;
      wr_reg(lpm_pkg::ADDR_IRQCFG, {29'h0, t[0], 2'b11});
      wr_reg(lpm_pkg::ADDR_CTRL2, 32'h04);
      step(3);
      check("tdoze ctrl", 32'h0d, {27'h0, ctrl[9:5]});
      check("latch set", 32'(t), 32'(n_lat - l));
      far.tick_fall();
      wait_res(r);
      check("tick vector", 32'(t), 32'(n_vtick - vt));
      rd_reg(lpm_pkg::ADDR_CTRL2);
      check("tick bit", 32'h0, {31'h0, rdata[2]});
    end
  endtask

  task automatic t_reset_mid();
    wr_reg(lpm_pkg::ADDR_CTRL2, 32'h10);
    step(3);
    @(posedge hclk);
    hresetn <= 1'b0;
    step(2);
    check("reset ctrl", 32'h840, {20'h0, ctrl});
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_reg(lpm_pkg::ADDR_STATUS);
    check("fast single", 32'h0, {26'h0, rdata[5:0]});
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_level();
    t_edge_halt();
    t_cpu_doze();
    t_wdt();
    t_tick();
    t_reset_mid();
    wrap_up();
  end
endmodule
